// >>> rtl/rts_timer_regs.vh
// Register offsets, field positions, reset values and timing counts for the reload timer.
`ifndef RTS_TIMER_REGS_VH
`define RTS_TIMER_REGS_VH
`define RTS_ADDR_CONTROL 8'h91
`define RTS_ADDR_RELOAD_LOW 8'h92
`define RTS_ADDR_RELOAD_HIGH 8'h93
`define RTS_ADDR_COUNT_LOW 8'h94
`define RTS_ADDR_COUNT_HIGH 8'h95
`define RTS_BIT_HIGH_OVF 7
`define RTS_BIT_LOW_OVF 6
`define RTS_BIT_LOW_IRQ_EN 5
`define RTS_BIT_SPARE 4
`define RTS_BIT_SPLIT 3
`define RTS_BIT_RUN 2
`define RTS_BIT_UNUSED 1
`define RTS_BIT_EXT_CLK 0
`define RTS_CONTROL_WMASK 8'hfd
`define RTS_RESET_BYTE 8'h00
`define RTS_PRESCALE_DIV 12
`define RTS_PRESCALE_W 4
`endif

// >>> rtl/rts_ext_tick.v
// Synchroniser and rising-edge detector for the divided external clock.
`timescale 1ns/100ps
`default_nettype none
module rts_ext_tick (
   // Clock and reset.
   input wire clk,
   input wire rst,
   // Divided external clock, asynchronous to clk.
   input wire ext_div_clk,
   // One-cycle tick per rising edge.
   output wire ext_tick
);
   reg sync1_ff;
   reg sync2_ff;
   reg sync3_ff;
   reg prev_ff;

   // The first stage feeds only the second; edges count once stages two and three agree.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         sync1_ff <= ext_div_clk;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         if (sync2_ff == sync3_ff) begin
            prev_ff <= sync3_ff;
         end
      end
   end

   // A single-cycle pulse when the agreed level rises.
   assign ext_tick = (sync2_ff == sync3_ff) && sync3_ff && !prev_ff;
endmodule // rts_ext_tick
`default_nettype wire

// >>> rtl/rts_timer.v
// Sixteen-bit auto-reload timer that splits into two eight-bit auto-reload timers.
`timescale 1ns/100ps
`default_nettype none
`include "rts_timer_regs.vh"
module rts_timer (
   // Clock and reset.
   input wire clk,
   input wire rst,
   // Special function register access.
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   // Clock sources and selects from outside the block.
   input wire ext_div_clk,
   input wire high_byte_fast_clock_sel,
   input wire low_byte_fast_clock_sel,
   // Interrupt request towards the interrupt controller.
   input wire timer_irq_enable,
   output wire timer_irq,
   // Count high byte, held in this block and driven out.
   output wire [7:0] count_high_byte
);
   reg [7:0] control_ff;
   reg [7:0] reload_low_byte_ff;
   reg [7:0] reload_high_byte_ff;
   reg [7:0] count_low_byte_ff;
   reg [7:0] count_high_ff;
   reg [`RTS_PRESCALE_W-1:0] presc_ff;
   reg [7:0] nxt_control;
   reg [7:0] nxt_low;
   reg [7:0] nxt_high;
   wire ext_tick;
   wire div12_tick;
   wire slow_tick;
   wire split_mode_select;
   wire run_control;
   wire ext_clock_select;
   wire low_tick;
   wire high_tick;
   wire low_wrap;
   wire high_wrap;
   wire low_ovf;
   wire high_ovf;
   wire wr_ctl;
   wire wr_cnt_lo;
   wire wr_cnt_hi;
   // Last prescaler state, cut to the prescaler width on purpose.
   localparam integer PRESC_LAST_I = `RTS_PRESCALE_DIV - 1;
   localparam [`RTS_PRESCALE_W-1:0] PRESC_LAST = PRESC_LAST_I[`RTS_PRESCALE_W-1:0];

   rts_ext_tick u_ext_tick (
      .clk(clk),
      .rst(rst),
      .ext_div_clk(ext_div_clk),
      .ext_tick(ext_tick)
   );

   // Write strobes per register.
   function is_wr;
      input [7:0] addr;
      input [7:0] target;
      input wr;
      begin
         is_wr = wr && (addr == target);
      end
   endfunction

   // All-ones detect; a byte at its top wraps on its next tick.
   function is_top;
      input [7:0] value;
      begin
         is_top = (value == 8'hff);
      end
   endfunction

   assign wr_ctl = is_wr(sfr_addr, `RTS_ADDR_CONTROL, sfr_wr);
   assign wr_cnt_lo = is_wr(sfr_addr, `RTS_ADDR_COUNT_LOW, sfr_wr);
   assign wr_cnt_hi = is_wr(sfr_addr, `RTS_ADDR_COUNT_HIGH, sfr_wr);
   assign split_mode_select = control_ff[`RTS_BIT_SPLIT];
   assign run_control = control_ff[`RTS_BIT_RUN];
   assign ext_clock_select = control_ff[`RTS_BIT_EXT_CLK];
   assign count_high_byte = count_high_ff;

   // Prescaler divides the core clock by twelve; it runs free so the phase is arbitrary.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         presc_ff <= {`RTS_PRESCALE_W{1'b0}};
      end else if (presc_ff == PRESC_LAST) begin
         presc_ff <= {`RTS_PRESCALE_W{1'b0}};
      end else begin
         presc_ff <= presc_ff + 1'b1;
      end
   end
   assign div12_tick = (presc_ff == PRESC_LAST);

   // Shared slow source, then per-byte fast override; run gates both bytes in 16-bit mode, only the high byte in split mode.
   // The external path costs three flops and an edge stage, so each count lags
   // its source edge by about four core clocks.
   assign slow_tick = ext_clock_select ? ext_tick : div12_tick;
   assign low_tick = (low_byte_fast_clock_sel ? 1'b1 : slow_tick) &&
                     (split_mode_select || run_control);
   assign high_tick = split_mode_select ?
                      ((high_byte_fast_clock_sel ? 1'b1 : slow_tick) && run_control) :
                      (low_tick && is_top(count_low_byte_ff));
   assign low_wrap = low_tick && is_top(count_low_byte_ff);
   assign high_wrap = high_tick && is_top(count_high_ff);
   assign low_ovf = low_wrap && !wr_cnt_lo;
   assign high_ovf = high_wrap && !wr_cnt_hi;

   // Next counter values; a software write wins over counting.
   // A write replaces only the byte written, so in 16-bit mode a carry into
   // the other byte in that same cycle still lands.
   always @* begin
      nxt_low = count_low_byte_ff;
      nxt_high = count_high_ff;
      if (split_mode_select) begin
         if (low_wrap) begin
            nxt_low = reload_low_byte_ff;
         end else if (low_tick) begin
            nxt_low = count_low_byte_ff + 8'h01;
         end
         if (high_wrap) begin
            nxt_high = reload_high_byte_ff;
         end else if (high_tick) begin
            nxt_high = count_high_ff + 8'h01;
         end
      end else begin
         if (high_wrap) begin
            nxt_low = reload_low_byte_ff;
            nxt_high = reload_high_byte_ff;
         end else if (low_tick) begin
            nxt_low = count_low_byte_ff + 8'h01;
            if (low_wrap) begin
               nxt_high = count_high_ff + 8'h01;
            end
         end
      end
      if (wr_cnt_lo) begin
         nxt_low = sfr_wdata;
      end
      if (wr_cnt_hi) begin
         nxt_high = sfr_wdata;
      end
   end

   // Control next value: bit 1 never stored; hardware set beats software clear.
   // The low flag follows every low-byte wrap in either mode, so a 16-bit user
   // with the low enable set sees one request per 256 counts.
   always @* begin
      nxt_control = control_ff;
      if (wr_ctl) begin
         nxt_control = sfr_wdata & `RTS_CONTROL_WMASK;
      end
      if (high_ovf) begin
         nxt_control[`RTS_BIT_HIGH_OVF] = 1'b1;
      end
      if (low_ovf) begin
         nxt_control[`RTS_BIT_LOW_OVF] = 1'b1;
      end
   end

   // Register file.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         control_ff <= `RTS_RESET_BYTE;
         reload_low_byte_ff <= `RTS_RESET_BYTE;
         reload_high_byte_ff <= `RTS_RESET_BYTE;
         count_low_byte_ff <= `RTS_RESET_BYTE;
         count_high_ff <= `RTS_RESET_BYTE;
      end else begin
         control_ff <= nxt_control;
         count_low_byte_ff <= nxt_low;
         count_high_ff <= nxt_high;
         if (is_wr(sfr_addr, `RTS_ADDR_RELOAD_LOW, sfr_wr)) begin
            reload_low_byte_ff <= sfr_wdata;
         end
         if (is_wr(sfr_addr, `RTS_ADDR_RELOAD_HIGH, sfr_wr)) begin
            reload_high_byte_ff <= sfr_wdata;
         end
      end
   end

   // Read data, registered; unmapped addresses read zero.
   // A count read shows the value at the address edge, one cycle behind the
   // live counter, which software must allow for when it polls a running byte.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
      end else begin
         case (sfr_addr)
            `RTS_ADDR_CONTROL: sfr_rdata <= control_ff;
            `RTS_ADDR_RELOAD_LOW: sfr_rdata <= reload_low_byte_ff;
            `RTS_ADDR_RELOAD_HIGH: sfr_rdata <= reload_high_byte_ff;
            `RTS_ADDR_COUNT_LOW: sfr_rdata <= count_low_byte_ff;
            `RTS_ADDR_COUNT_HIGH: sfr_rdata <= count_high_ff;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // Interrupt is a level from the sticky flags; software clears them to drop it.
   assign timer_irq = timer_irq_enable && (control_ff[`RTS_BIT_HIGH_OVF] ||
                      (control_ff[`RTS_BIT_LOW_IRQ_EN] && control_ff[`RTS_BIT_LOW_OVF]));
endmodule // rts_timer
`default_nettype wire

// >>> verif/rts_timer_properties.sv
// Port-level checker for the split-mode reload timer.
`timescale 1ns/100ps
`default_nettype none
module rts_timer_properties (
   // Clock and reset.
   input wire clk,
   input wire rst,
   // Register access.
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire [7:0] sfr_wdata,
   input wire [7:0] sfr_rdata,
   // Timer outputs and enable.
   input wire timer_irq_enable,
   input wire timer_irq,
   input wire [7:0] count_high_byte
);
   reg run_ff;
   wire wc = sfr_wr && sfr_addr == 8'h91;
   wire wh = sfr_wr && sfr_addr == 8'h95;
   // Shadow of the run bit; only software moves it, so a copy is exact.
   always @(posedge clk or posedge rst) begin
      if (rst) run_ff <= 1'b0;
      else if (wc) run_ff <= sfr_wdata[2];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_unused; $past(sfr_addr) == 8'h91 |-> !sfr_rdata[1]; endproperty
   a_unused: assert property (p_unused) else $error("bit 1 reads 1");
   property p_rll; (sfr_wr && sfr_addr == 8'h92) ##1 (!sfr_wr && sfr_addr == 8'h92)
      |=> sfr_rdata == $past(sfr_wdata, 2); endproperty
   a_rll: assert property (p_rll) else $error("reload low lost");
   property p_rlh; (sfr_wr && sfr_addr == 8'h93) ##1 (!sfr_wr && sfr_addr == 8'h93)
      |=> sfr_rdata == $past(sfr_wdata, 2); endproperty
   a_rlh: assert property (p_rlh) else $error("reload high lost");
   property p_cnt; (sfr_wr && sfr_addr == 8'h94) ##1 (!sfr_wr && sfr_addr == 8'h94)
      |=> sfr_rdata == $past(sfr_wdata, 2); endproperty
   a_cnt: assert property (p_cnt) else $error("count low write lost");
   property p_chw; wh |=> count_high_byte == $past(sfr_wdata); endproperty
   a_chw: assert property (p_chw) else $error("count high write lost");
   property p_stop; !run_ff && !wh |=> $stable(count_high_byte); endproperty
   a_stop: assert property (p_stop) else $error("high byte ran");
   property p_irqen; !timer_irq_enable |-> !timer_irq; endproperty
   a_irqen: assert property (p_irqen) else $error("irq while off");
   property p_sticky; $fell(timer_irq) |-> $past(wc) || $fell(timer_irq_enable); endproperty
   a_sticky: assert property (p_sticky) else $error("flag self-cleared");
endmodule // rts_timer_properties
bind rts_timer rts_timer_properties rts_timer_properties_i (.clk(clk), .rst(rst),
   .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq),
   .count_high_byte(count_high_byte));
`default_nettype wire

// >>> verif/rts_timer_tb.sv
// Self-checking bench for the split-mode reload timer.
`timescale 1ns/100ps
`default_nettype none
module rts_timer_tb;
   reg clk = 1'b0, rst = 1'b1, wr = 1'b0, ext = 1'b0, fh = 1'b0, fl = 1'b0, ien = 1'b0;
   reg [7:0] a = 8'h00, wd = 8'h00;
   wire [7:0] rd, ch;
   wire irq;
   integer i, fail_count = 0, compares = 0;
   // Rows: address, written byte, byte read back.
   reg [23:0] rows [0:4];
   rts_timer rts_timer_i (.clk(clk), .rst(rst), .sfr_addr(a), .sfr_wr(wr), .sfr_wdata(wd),
      .sfr_rdata(rd), .ext_div_clk(ext), .high_byte_fast_clock_sel(fh),
      .low_byte_fast_clock_sel(fl), .timer_irq_enable(ien), .timer_irq(irq),
      .count_high_byte(ch));
   always #25 clk = ~clk;
   task chk(input [7:0] e, input [7:0] g, input string n);
      begin
         compares = compares + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("FAIL %0s exp %h got %h", n, e, g);
         end
      end
   endtask
   task w(input [7:0] ad, input [7:0] d);
      begin
         @(posedge clk);
         a <= ad;
         wd <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   // Read data is registered, so it is looked at two edges after the address.
   task r(input [7:0] ad);
      begin
         @(posedge clk);
         a <= ad;
         repeat (2) @(posedge clk);
         #1;
      end
   endtask
   task test_done;
      begin
         $display("compares %0d fail_count %0d", compares, fail_count);
         if (fail_count == 0 && compares > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // Watchdog: the whole run needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clk);
      fail_count = fail_count + 1;
      test_done;
   end
   initial begin
      rows[0] = 24'h92a5a5;
      rows[1] = 24'h935a5a;
      rows[2] = 24'h911210;
      rows[3] = 24'h80ff00;
      rows[4] = 24'h953c3c;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
         r(8'h91 + i[7:0]);
         chk(8'h00, rd, "reset");
      end
      $display("end reset");
      for (i = 0; i < 5; i = i + 1) begin
         w(rows[i][23:16], rows[i][15:8]);
         r(rows[i][23:16]);
         chk(rows[i][7:0], rd, "row");
      end
      $display("end rows");
      // Prescaled count: roughly 122 cycles at one tick per 12 gives 10 or 11.
      w(8'h94, 8'h00);
      w(8'h91, 8'h04);
      repeat (120) @(posedge clk);
      w(8'h91, 8'h00);
      r(8'h94);
      chk(8'h01, {7'h00, rd == 8'h0a || rd == 8'h0b}, "div12");
      // Full-rate 16-bit wrap from 0xfffe; writing 1 to the flag keeps it.
      w(8'h92, 8'h34);
      w(8'h93, 8'h12);
      w(8'h95, 8'hff);
      w(8'h94, 8'hfe);
      fl <= 1'b1;
      ien <= 1'b1;
      w(8'h91, 8'h04);
      repeat (4) @(posedge clk);
      w(8'h91, 8'h80);
      #1;
      chk(8'h12, ch, "reload");
      r(8'h91);
      chk(8'h80, rd, "flag16");
      repeat (5) @(posedge clk);
      #1;
      chk(8'h01, {7'h00, irq}, "irq");
      w(8'h91, 8'h00);
      r(8'h91);
      chk(8'h00, {7'h00, irq}, "clear");
      $display("end wide");
      // Split mode with run clear: the low byte wraps, the high byte stays.
      w(8'h92, 8'hf0);
      w(8'h95, 8'h40);
      w(8'h91, 8'h08);
      // Loaded while the low byte runs, so the write must beat the increment.
      w(8'h94, 8'hf0);
      repeat (40) @(posedge clk);
      #1;
      chk(8'h40, ch, "hstop");
      chk(8'h00, {7'h00, irq}, "lmask");
      r(8'h94);
      chk(8'hf0, rd & 8'hf0, "low");
      r(8'h91);
      chk(8'h48, rd, "flag8");
      w(8'h91, 8'h68);
      r(8'h91);
      chk(8'h01, {7'h00, irq}, "lirq");
      @(posedge clk);
      fh <= 1'b1;
      w(8'h91, 8'h2c);
      repeat (10) @(posedge clk);
      #1;
      chk(8'h01, {7'h00, ch != 8'h40}, "hrun");
      $display("end split");
      // External divided clock: five rising edges give five counts.
      @(posedge clk);
      fh <= 1'b0;
      fl <= 1'b0;
      w(8'h91, 8'h01);
      w(8'h94, 8'h00);
      w(8'h91, 8'h05);
      repeat (5) begin
         ext <= 1'b1;
         repeat (8) @(posedge clk);
         ext <= 1'b0;
         repeat (8) @(posedge clk);
      end
      w(8'h91, 8'h01);
      r(8'h94);
      chk(8'h05, rd, "ext");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      r(8'h91);
      chk(8'h00, rd, "rerst");
      chk(8'h00, ch, "rerst_high");
      $display("end ext");
      test_done;
   end
endmodule // rts_timer_tb
`default_nettype wire
